// ===== hw/virq_pkg.sv
// constants and carrier types of the vectored interrupt and wake controller
package virq_pkg;
   localparam int NSRC = 14;
   // register offsets
   localparam logic [7:0] OFS_PINEN  = 8'h84;
   localparam logic [7:0] OFS_PINFLG = 8'h85;
   localparam logic [7:0] OFS_TCTL   = 8'h88;
   localparam logic [7:0] OFS_FLG    = 8'h95;
   localparam logic [7:0] OFS_P1WK   = 8'h96;
   localparam logic [7:0] OFS_PWM_OUTPUT_AND_IRQ_CTRL  = 8'h9E;
   localparam logic [7:0] OFS_PWM_CLEAR_AND_IRQ_CTRL = 8'h9F;
   localparam logic [7:0] OFS_IEN    = 8'hA8;
   localparam logic [7:0] OFS_IEN1   = 8'hA9;
   localparam logic [7:0] OFS_PRIL   = 8'hB8;
   localparam logic [7:0] OFS_PRIH   = 8'hB9;
   localparam logic [7:0] OFS_PRI1L  = 8'hBA;
   localparam logic [7:0] OFS_PRI1H  = 8'hBB;
   // reset values
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_FLAGS   = 8'h00;
   localparam logic [7:0] RST_PRIO    = 8'h00;
   // base enable register fields
   localparam int B_GATE = 7;
   localparam int B_RSVD = 6;
   localparam int B_TMR2 = 5;
   localparam int B_UART1 = 4;
   localparam int B_TMR1 = 3;
   localparam int B_PIN1EN = 2;
   localparam int B_TMR0 = 1;
   localparam int B_PIN0EN = 0;
   // extended enable register fields
   localparam int B_PWMGRP = 7;
   localparam int B_TWI = 6;
   localparam int B_PINLV = 2;
   localparam int B_P1CHG = 1;
   // pwm channel enables, trigger control, flags
   localparam int B_PWM1EN = 7;
   localparam int B_PWM0EN = 6;
   localparam int B_PWM2EN = 7;
   localparam int B_PIN1FLG = 3;
   localparam int B_PIN1TRIG = 2;
   localparam int B_PIN0FLG = 1;
   localparam int B_PIN0TRIG = 0;
   localparam int B_LVFLG = 7;
   localparam int B_P1FLG = 1;
   // source slots in polling order
   localparam logic [3:0] S_PIN0 = 4'h0;
   localparam logic [3:0] S_PIN1 = 4'h2;
   localparam logic [3:0] S_P1 = 4'h7;
   localparam logic [4:0] RSV_SLOT = 5'h06;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [15:0] VEC_RSV = 16'h0033;

   typedef struct packed {
      logic       timer_zero_overflow;
      logic       timer_one_overflow;
      logic       timer_two_overflow;
      logic       timer_two_external_flag;
      logic       timer_three_flag;
      logic       uart1_rx_done;
      logic       uart1_tx_done;
      logic       uart2_rx_done;
      logic       uart2_tx_done;
      logic       lowvolt_detect_flag;
      logic       converter_done_flag;
      logic       touch_key_flag;
      logic       serial_xfer_done;
      logic       serial_write_collision;
      logic       serial_mode_fault;
      logic [3:0] twowire_flags;
      logic       pwm_ch0_flag;
      logic       pwm_ch1_flag;
      logic       pwm_ch2_flag;
   } virq_flags_t;

   typedef struct packed {
      logic        req;
      logic [15:0] vector;
      logic [1:0]  level;
   } virq_irq_t;
endpackage

// ===== hw/virq_ctrl.sv
// interrupt arbiter, vector source and wake logic for an 8051-style core
`timescale 1ns/1ps
module virq_ctrl (
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic [7:0]           bus_addr,
   input  wire logic [7:0]           bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output      logic [7:0]           bus_rdata,
   input  wire virq_pkg::virq_flags_t periph_flags,
   input  wire logic [9:0]           ext_pin,
   input  wire logic [7:0]           port1_pin,
   input  wire logic                 core_ack,
   input  wire logic                 core_reti,
   output      virq_pkg::virq_irq_t  irq_out,
   output      logic                 idle_wake,
   output      logic                 halt_wake,
   output      logic                 pd_refuse
);
   logic [9:0]  pin_s1_reg, pin_s2_reg, pin_prev_reg;
   logic [7:0]  p1_s1_reg, p1_s2_reg, p1_prev_reg;
   logic [7:0]  pin_en_reg, pin_flg_reg, p1wk_reg, ien_reg, ien1_reg;
   logic [7:0]  pri1l_reg, pri1h_reg, rdata_reg;
   logic [5:0]  pril_reg, prih_reg;
   logic [1:0]  trig_reg, edge_reg, pwm_output_and_irq_ctrl_reg;
   logic        pwm2en_reg, p1flg_reg;
   logic [3:0]  insvc_reg, idx_reg;
   logic        idle_wake_reg, halt_wake_reg, pd_refuse_reg;
   virq_pkg::virq_irq_t irq_reg;

   // winner search: lowest slot wins among the highest level
   function automatic logic [6:0] pick(input logic [13:0] rq,
                                       input logic [13:0] hi,
                                       input logic [13:0] lo);
      logic       found;
      logic [3:0] best;
      logic [1:0] lvl;
      found = 1'b0;
      best = 4'h0;
      lvl = 2'h0;
      for (int i = virq_pkg::NSRC - 1; i >= 0; i--) begin
         if (rq[i] && (!found || {hi[i], lo[i]} >= lvl)) begin
            found = 1'b1;
            best = 4'(i);
            lvl = {hi[i], lo[i]};
         end
      end
      return {found, best, lvl};
   endfunction

   // every slot from the reserved one on moves up one, skipping it
   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      logic [4:0] slot;
      slot = {1'b0, idx};
      if (slot >= virq_pkg::RSV_SLOT) begin
         slot = slot + 5'h01;
      end
      return virq_pkg::VEC_BASE + {11'h000, slot} * virq_pkg::VEC_STEP;
   endfunction

   // highest level now in service
   function automatic logic [2:0] top_of(input logic [3:0] sv);
      logic [2:0] t;
      t = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (sv[i]) begin
            t = {1'b1, 2'(i)};
         end
      end
      return t;
   endfunction

   // pin side: both ports are asynchronous to this clock
   wire [9:0] fall = pin_prev_reg & ~pin_s2_reg;
   wire [7:0] p1_chg = (p1_s2_reg ^ p1_prev_reg) & p1wk_reg;

   // register write decode
   wire wr_pinen  = bus_wr && bus_addr == virq_pkg::OFS_PINEN;
   wire wr_pinflg = bus_wr && bus_addr == virq_pkg::OFS_PINFLG;
   wire wr_tctl   = bus_wr && bus_addr == virq_pkg::OFS_TCTL;
   wire wr_flg    = bus_wr && bus_addr == virq_pkg::OFS_FLG;
   wire wr_p1wk   = bus_wr && bus_addr == virq_pkg::OFS_P1WK;
   wire wr_pwm_output_and_irq_ctrl  = bus_wr && bus_addr == virq_pkg::OFS_PWM_OUTPUT_AND_IRQ_CTRL;
   wire wr_pwm_clear_and_irq_ctrl = bus_wr && bus_addr == virq_pkg::OFS_PWM_CLEAR_AND_IRQ_CTRL;
   wire wr_ien    = bus_wr && bus_addr == virq_pkg::OFS_IEN;
   wire wr_ien1   = bus_wr && bus_addr == virq_pkg::OFS_IEN1;
   wire wr_pril   = bus_wr && bus_addr == virq_pkg::OFS_PRIL;
   wire wr_prih   = bus_wr && bus_addr == virq_pkg::OFS_PRIH;
   wire wr_pri1l  = bus_wr && bus_addr == virq_pkg::OFS_PRI1L;
   wire wr_pri1h  = bus_wr && bus_addr == virq_pkg::OFS_PRI1H;

   // acknowledge only counts while a request is shown
   wire ack_ok = core_ack && irq_reg.req;
   wire ack_pin0 = ack_ok && idx_reg == virq_pkg::S_PIN0;
   wire ack_pin1 = ack_ok && idx_reg == virq_pkg::S_PIN1;
   wire ack_p1 = ack_ok && idx_reg == virq_pkg::S_P1;

   // level mode shows the synchronised pin inverted; edge mode the latched flag
   wire pin0_flag = trig_reg[0] ? edge_reg[0] : !pin_s2_reg[0];
   wire pin1_flag = trig_reg[1] ? edge_reg[1] : !pin_s2_reg[1];
   wire [1:0] edge_set = trig_reg & fall[1:0];
   wire [1:0] edge_ack = {ack_pin1 && trig_reg[1], ack_pin0 && trig_reg[0]};
   wire [1:0] edge_wr = {bus_wdata[virq_pkg::B_PIN1FLG], bus_wdata[virq_pkg::B_PIN0FLG]};
   // set beats both the software clear and the service clear
   wire [1:0] edge_next = edge_set | (wr_tctl ? edge_wr : edge_reg & ~edge_ack);
   wire [7:0] pin_flg_next = fall[9:2] | (wr_pinflg ? bus_wdata : pin_flg_reg);
   wire p1flg_next = (|p1_chg) |
                     (wr_flg ? bus_wdata[virq_pkg::B_P1FLG] : p1flg_reg && !ack_p1);

   // pending flags per slot, source enable ignored here; pin and pwm channel enables applied
   virq_pkg::virq_flags_t pf;
   assign pf = periph_flags;
   wire grp_pins = |(pin_en_reg & pin_flg_reg) || pf.lowvolt_detect_flag;
   wire pwm_any = (pf.pwm_ch0_flag && pwm_output_and_irq_ctrl_reg[0]) ||
                  (pf.pwm_ch1_flag && pwm_output_and_irq_ctrl_reg[1]) ||
                  (pf.pwm_ch2_flag && pwm2en_reg);
   wire [13:0] pend = {pwm_any,
                       |pf.twowire_flags,
                       pf.uart2_rx_done || pf.uart2_tx_done,
                       pf.serial_xfer_done || pf.serial_write_collision ||
                       pf.serial_mode_fault,
                       pf.converter_done_flag || pf.touch_key_flag,
                       grp_pins,
                       p1flg_reg,
                       pf.timer_three_flag,
                       pf.timer_two_overflow || pf.timer_two_external_flag,
                       pf.uart1_rx_done || pf.uart1_tx_done,
                       pf.timer_one_overflow,
                       pin1_flag,
                       pf.timer_zero_overflow,
                       pin0_flag};
   wire [13:0] srcen = {ien1_reg[7:1], ien1_reg[0],
                        ien_reg[virq_pkg::B_TMR2], ien_reg[virq_pkg::B_UART1],
                        ien_reg[virq_pkg::B_TMR1], ien_reg[virq_pkg::B_PIN1EN],
                        ien_reg[virq_pkg::B_TMR0],
                        ien_reg[virq_pkg::B_PIN0EN]};
   wire global_irq_gate = ien_reg[virq_pkg::B_GATE];
   wire [13:0] req = global_irq_gate ? pend & srcen : 14'h0000;

   // priority bits, two per source
   wire [13:0] pri_hi = {pri1h_reg, prih_reg};
   wire [13:0] pri_lo = {pri1l_reg, pril_reg};
   wire [6:0] cand = pick(req, pri_hi, pri_lo);
   wire [2:0] top = top_of(insvc_reg);
   // equal or higher level in service holds the newcomer back
   wire cand_ok = cand[6] && (!top[2] || cand[1:0] > top[1:0]);
   wire irq_req_next = cand_ok && !core_ack && !core_reti;

   // nesting: return pops the highest level, acknowledge pushes one
   wire [3:0] pop_mask = top[2] && core_reti ? 4'h1 << top[1:0] : 4'h0;
   wire [3:0] push_mask = ack_ok ? 4'h1 << irq_reg.level : 4'h0;
   wire [3:0] insvc_next = (insvc_reg & ~pop_mask) | push_mask;

   // halt wake and power-down refusal: pin sources ignore the global gate
   wire halt_wake_next = (ien_reg[virq_pkg::B_PIN0EN] && pin0_flag) ||
                         (ien_reg[virq_pkg::B_PIN1EN] && pin1_flag) ||
                         (ien1_reg[virq_pkg::B_PINLV] && |(pin_en_reg & pin_flg_reg)) ||
                         p1flg_reg;
   wire [9:0] wake_en = {pin_en_reg, ien_reg[virq_pkg::B_PIN1EN], ien_reg[virq_pkg::B_PIN0EN]};
   wire pd_refuse_next = |(wake_en & ~pin_s2_reg);

   // read mux; unmapped addresses read zero
   wire [7:0] rd_mux =
      bus_addr == virq_pkg::OFS_PINEN  ? pin_en_reg :
      bus_addr == virq_pkg::OFS_PINFLG ? pin_flg_reg :
      bus_addr == virq_pkg::OFS_TCTL   ? {4'h0, pin1_flag, trig_reg[1], pin0_flag, trig_reg[0]} :
      bus_addr == virq_pkg::OFS_FLG    ? {pf.lowvolt_detect_flag, 5'h00, p1flg_reg, 1'b0} :
      bus_addr == virq_pkg::OFS_P1WK   ? p1wk_reg :
      bus_addr == virq_pkg::OFS_PWM_OUTPUT_AND_IRQ_CTRL  ? {pwm_output_and_irq_ctrl_reg[1], pwm_output_and_irq_ctrl_reg[0], 6'h00} :
      bus_addr == virq_pkg::OFS_PWM_CLEAR_AND_IRQ_CTRL ? {pwm2en_reg, 7'h00} :
      bus_addr == virq_pkg::OFS_IEN    ? ien_reg :
      bus_addr == virq_pkg::OFS_IEN1   ? ien1_reg :
      bus_addr == virq_pkg::OFS_PRIL   ? {2'h0, pril_reg} :
      bus_addr == virq_pkg::OFS_PRIH   ? {2'h0, prih_reg} :
      bus_addr == virq_pkg::OFS_PRI1L  ? pri1l_reg :
      bus_addr == virq_pkg::OFS_PRI1H  ? pri1h_reg : 8'h00;

   // synchronisers; first stage feeds only the second
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_reg <= 10'h3FF;
         pin_s2_reg <= 10'h3FF;
         pin_prev_reg <= 10'h3FF;
         p1_s1_reg <= 8'h00;
         p1_s2_reg <= 8'h00;
         p1_prev_reg <= 8'h00;
      end else begin
         pin_s1_reg <= ext_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_prev_reg <= pin_s2_reg;
         p1_s1_reg <= port1_pin;
         p1_s2_reg <= p1_s1_reg;
         p1_prev_reg <= p1_s2_reg;
      end
   end

   // software registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_en_reg <= virq_pkg::RST_ENABLES;
         p1wk_reg <= virq_pkg::RST_ENABLES;
         ien_reg <= virq_pkg::RST_ENABLES;
         ien1_reg <= virq_pkg::RST_ENABLES;
         pwm_output_and_irq_ctrl_reg <= 2'h0;
         pwm2en_reg <= 1'b0;
         trig_reg <= 2'h0;
         pril_reg <= 6'h00;
         prih_reg <= 6'h00;
         pri1l_reg <= virq_pkg::RST_PRIO;
         pri1h_reg <= virq_pkg::RST_PRIO;
      end else begin
         if (wr_pinen) pin_en_reg <= bus_wdata;
         if (wr_p1wk) p1wk_reg <= bus_wdata;
         if (wr_ien) ien_reg <= bus_wdata & ~(8'h01 << virq_pkg::B_RSVD);
         if (wr_ien1) ien1_reg <= bus_wdata;
         if (wr_pwm_output_and_irq_ctrl) pwm_output_and_irq_ctrl_reg <= {bus_wdata[virq_pkg::B_PWM1EN], bus_wdata[virq_pkg::B_PWM0EN]};
         if (wr_pwm_clear_and_irq_ctrl) pwm2en_reg <= bus_wdata[virq_pkg::B_PWM2EN];
         if (wr_tctl) begin
            trig_reg <= {bus_wdata[virq_pkg::B_PIN1TRIG], bus_wdata[virq_pkg::B_PIN0TRIG]};
         end
         if (wr_pril) pril_reg <= bus_wdata[5:0];
         if (wr_prih) prih_reg <= bus_wdata[5:0];
         if (wr_pri1l) pri1l_reg <= bus_wdata;
         if (wr_pri1h) pri1h_reg <= bus_wdata;
      end
   end

   // flags, arbitration state and outputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         edge_reg <= 2'h0;
         pin_flg_reg <= virq_pkg::RST_FLAGS;
         p1flg_reg <= 1'b0;
         insvc_reg <= 4'h0;
         idx_reg <= 4'h0;
         irq_reg <= '0;
         idle_wake_reg <= 1'b0;
         halt_wake_reg <= 1'b0;
         pd_refuse_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         edge_reg <= edge_next;
         pin_flg_reg <= pin_flg_next;
         p1flg_reg <= p1flg_next;
         insvc_reg <= insvc_next;
         idx_reg <= cand[5:2];
         irq_reg.req <= irq_req_next;
         irq_reg.vector <= vec_of(cand[5:2]);
         irq_reg.level <= cand[1:0];
         idle_wake_reg <= |req;
         halt_wake_reg <= halt_wake_next;
         pd_refuse_reg <= pd_refuse_next;
         rdata_reg <= bus_rd ? rd_mux : 8'h00;
      end
   end

   assign bus_rdata = rdata_reg;
   assign irq_out = irq_reg;
   assign idle_wake = idle_wake_reg;
   assign halt_wake = halt_wake_reg;
   assign pd_refuse = pd_refuse_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   property p_gate_blocks;
      !global_irq_gate |=> !irq_reg.req;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) else $error("request despite gate off");

   property p_vec_shape;
      irq_reg.req |-> irq_reg.vector[2:0] == 3'h3 && irq_reg.vector != virq_pkg::VEC_RSV
                      && irq_reg.vector <= 16'h0073;
   endproperty
   a_vec_shape: assert property (p_vec_shape) else $error("bad vector");

   property p_vec_tie;
      irq_reg.req |-> (idx_reg == virq_pkg::S_PIN0) == (irq_reg.vector == 16'h0003)
                      && (idx_reg == virq_pkg::S_P1) == (irq_reg.vector == 16'h0043);
   endproperty
   a_vec_tie: assert property (p_vec_tie) else $error("vector not of slot");

   property p_no_equal;
      irq_reg.req |-> (insvc_reg >> irq_reg.level) == 4'h0;
   endproperty
   a_no_equal: assert property (p_no_equal) else $error("request at busy level");

   property p_push;
      ack_ok |=> insvc_reg[$past(irq_reg.level)] && !irq_reg.req;
   endproperty
   a_push: assert property (p_push) else $error("ack not recorded");

   property p_edge_sticky;
      fall[2] |=> pin_flg_reg[0];
   endproperty
   a_edge_sticky: assert property (p_edge_sticky) else $error("pin flag lost");

   property p_auto_clear;
      ack_pin0 && trig_reg[0] && !fall[0] && !wr_tctl |=> !edge_reg[0];
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("pin 0 flag kept");

   sequence s_pin2_low_en;
      pin_en_reg[0] && !pin_s2_reg[2];
   endsequence
   property p_refuse;
      s_pin2_low_en |=> pd_refuse_reg;
   endproperty
   a_refuse: assert property (p_refuse) else $error("power-down not refused");

   sequence s_p1_change;
      p1_chg != 8'h00;
   endsequence
   property p_p1_wake;
      s_p1_change |=> p1flg_reg ##1 halt_wake_reg;
   endproperty
   a_p1_wake: assert property (p_p1_wake) else $error("port1 change no wake");

   property p_idle_wake;
      req != 14'h0000 |=> idle_wake_reg;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");

   // a return frees exactly one level
   property p_pop;
      core_reti && !ack_ok && insvc_reg != 4'h0
      |=> $countones(insvc_reg) + 1 == $countones($past(insvc_reg));
   endproperty
   a_pop: assert property (p_pop) else $error("return did not free one level");

   property p_pin0_level;
      !trig_reg[0] && !pin_s2_reg[0] && ien_reg[virq_pkg::B_PIN0EN] |=> halt_wake_reg;
   endproperty
   a_pin0_level: assert property (p_pin0_level) else $error("low pin 0 no wake");

   property p_pwm_group;
      !ien1_reg[virq_pkg::B_PWMGRP] |=> !irq_reg.req || irq_reg.vector != 16'h0073;
   endproperty
   a_pwm_group: assert property (p_pwm_group) else $error("pwm request without group");

   // without the shared enable, pins 2 to 9 alone never wake
   property p_halt_lv;
      !ien1_reg[virq_pkg::B_PINLV] && !ien_reg[virq_pkg::B_PIN0EN] &&
      !ien_reg[virq_pkg::B_PIN1EN] && !p1flg_reg |=> !halt_wake_reg;
   endproperty
   a_halt_lv: assert property (p_halt_lv) else $error("wake without shared enable");
endmodule // virq_ctrl

// ===== tb/virq_core_model.sv
// core-side model that takes shown requests and returns from service on command
`timescale 1ns/1ps
module virq_core_model (
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire virq_pkg::virq_irq_t irq,
   input  wire logic                take,
   input  wire logic                ret,
   output      logic                core_ack,
   output      logic                core_reti,
   output      logic [15:0]         taken_vec
);
   // acks only a request that is shown, and never two cycles running
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         core_ack  <= 1'b0;
         core_reti <= 1'b0;
         taken_vec <= 16'h0000;
      end else begin
         core_ack  <= take && irq.req && !core_ack;
         core_reti <= ret;
         if (take && irq.req) begin
            taken_vec <= irq.vector;
         end
      end
   end
endmodule // virq_core_model

// ===== tb/tb_vectored_irq_priority_wake.sv
// self-checking bench for the vectored interrupt and wake controller
`timescale 1ns/1ps
module tb_vectored_irq_priority_wake;
   logic                  clock, arst_n, bus_wr, bus_rd, take, ret;
   logic [7:0]            bus_addr, bus_wdata, bus_rdata, port1_pin;
   logic [9:0]            ext_pin;
   virq_pkg::virq_flags_t periph_flags;
   virq_pkg::virq_irq_t   irq_out;
   logic                  core_ack, core_reti, idle_wake, halt_wake, pd_refuse;
   logic [15:0]           taken_vec;
   int                    mismatches, cmp_count, cyc;
   // carrier bit of each single-flag source and the vector it must give
   int                    fidx [11] = '{21, 20, 16, 19, 17, 12, 11, 9, 14, 6, 2};
   logic [15:0]           fvec [11] = '{16'h000B, 16'h001B, 16'h0023, 16'h002B, 16'h003B,
                                        16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B,
                                        16'h0073};

   virq_ctrl i_virq_ctrl (
      .clock(clock), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .periph_flags(periph_flags),
      .ext_pin(ext_pin), .port1_pin(port1_pin), .core_ack(core_ack), .core_reti(core_reti),
      .irq_out(irq_out), .idle_wake(idle_wake), .halt_wake(halt_wake), .pd_refuse(pd_refuse)
   );

   virq_core_model i_virq_core_model (
      .clock(clock), .arst_n(arst_n), .irq(irq_out), .take(take), .ret(ret),
      .core_ack(core_ack), .core_reti(core_reti), .taken_vec(taken_vec)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // cuts a hang short well beyond the few hundred cycles the tests need
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clock);
      bus_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clock);
      bus_rd   <= 1'b0;
      #1;
      chk({8'h00, bus_rdata}, {8'h00, exp});
   endtask

   task automatic wcyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // pins pass two synchronising stages, so eight cycles covers any path
   task automatic wreq(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge clock);
         #1;
         if (irq_out.req === 1'b1)
            seen = 1'b1;
      end
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask

   task automatic setf(input logic [21:0] v);
      @(posedge clock);
      periph_flags <= v;
   endtask

   task automatic pins(input logic [9:0] e, input logic [7:0] p);
      @(posedge clock);
      ext_pin   <= e;
      port1_pin <= p;
   endtask

   task automatic core(input logic t, input logic r);
      @(posedge clock);
      take <= t;
      ret  <= r;
      @(posedge clock);
      take <= 1'b0;
      ret  <= 1'b0;
      wcyc(2);
   endtask

   initial begin
      arst_n = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      take = 1'b0;
      ret = 1'b0;
      ext_pin = 10'h3FF;
      port1_pin = 8'h00;
      periph_flags = 22'h000000;
      mismatches = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      rdchk(virq_pkg::OFS_PINEN, 8'h00);
      rdchk(virq_pkg::OFS_P1WK, 8'h00);
      rdchk(virq_pkg::OFS_IEN1, 8'h00);
      wr(virq_pkg::OFS_IEN, 8'hFF);
      rdchk(virq_pkg::OFS_IEN, 8'hBF);
      rdchk(8'h00, 8'h00);
      $display("test registers done");
      wr(virq_pkg::OFS_IEN1, 8'hFF);
      // pwm settings come only from this main sequence, never from a service context
      wr(virq_pkg::OFS_PWM_OUTPUT_AND_IRQ_CTRL, 8'hC0);
      wr(virq_pkg::OFS_PWM_CLEAR_AND_IRQ_CTRL, 8'h80);
      for (int i = 0; i < 11; i++) begin
         setf(22'h000001 << fidx[i]);
         wreq(1'b1);
         chk(irq_out.vector, fvec[i]);
      end
      wr(virq_pkg::OFS_IEN1, 8'h7F);
      wreq(1'b0);
      wr(virq_pkg::OFS_IEN1, 8'hFF);
      wr(virq_pkg::OFS_IEN, 8'h3F);
      wreq(1'b0);
      chk({15'h0000, idle_wake}, 16'h0000);
      wr(virq_pkg::OFS_IEN, 8'hBF);
      $display("test vectors done");
      setf(22'h300000);
      wreq(1'b1);
      chk(irq_out.vector, 16'h000B);
      wr(virq_pkg::OFS_PRIL, 8'h08);
      wreq(1'b1);
      chk(irq_out.vector, 16'h001B);
      chk({14'h0000, irq_out.level}, 16'h0001);
      wr(virq_pkg::OFS_PRIH, 8'h02);
      wreq(1'b1);
      chk(irq_out.vector, 16'h000B);
      chk({14'h0000, irq_out.level}, 16'h0002);
      wr(virq_pkg::OFS_PRIH, 8'h0A);
      wreq(1'b1);
      chk({14'h0000, irq_out.level}, 16'h0003);
      wr(virq_pkg::OFS_PRIH, 8'h00);
      setf(22'h200000);
      wreq(1'b1);
      core(1'b1, 1'b0);
      chk(taken_vec, 16'h000B);
      setf(22'h010000);
      wreq(1'b0);
      setf(22'h110000);
      wreq(1'b1);
      chk(irq_out.vector, 16'h001B);
      core(1'b1, 1'b0);
      setf(22'h010000);
      core(1'b0, 1'b1);
      wreq(1'b0);
      core(1'b0, 1'b1);
      wreq(1'b1);
      chk(irq_out.vector, 16'h0023);
      setf(22'h000000);
      wr(virq_pkg::OFS_PRIL, 8'h00);
      wr(virq_pkg::OFS_IEN1, 8'h00);
      $display("test priority done");
      wr(virq_pkg::OFS_TCTL, 8'h01);
      wr(virq_pkg::OFS_IEN, 8'h81);
      pins(10'h3FE, 8'h00);
      wreq(1'b1);
      chk(irq_out.vector, 16'h0003);
      chk({15'h0000, pd_refuse}, 16'h0001);
      core(1'b1, 1'b0);
      rdchk(virq_pkg::OFS_TCTL, 8'h01);
      core(1'b0, 1'b1);
      pins(10'h3FF, 8'h00);
      wcyc(4);
      chk({15'h0000, pd_refuse}, 16'h0000);
      wr(virq_pkg::OFS_IEN, 8'h01);
      pins(10'h3FE, 8'h00);
      wreq(1'b0);
      chk({15'h0000, halt_wake}, 16'h0001);
      pins(10'h3FF, 8'h00);
      wr(virq_pkg::OFS_TCTL, 8'h00);
      wr(virq_pkg::OFS_IEN, 8'h81);
      pins(10'h3FE, 8'h00);
      wreq(1'b1);
      rdchk(virq_pkg::OFS_TCTL, 8'h02);
      pins(10'h3FF, 8'h00);
      wcyc(4);
      chk({15'h0000, irq_out.req}, 16'h0000);
      wr(virq_pkg::OFS_TCTL, 8'h01);
      wr(virq_pkg::OFS_IEN, 8'h00);
      $display("test pin zero done");
      wr(virq_pkg::OFS_PINEN, 8'h01);
      pins(10'h3F3, 8'h00);
      wcyc(6);
      chk({15'h0000, halt_wake}, 16'h0000);
      rdchk(virq_pkg::OFS_PINFLG, 8'h03);
      wr(virq_pkg::OFS_IEN1, 8'h04);
      wcyc(3);
      chk({15'h0000, halt_wake}, 16'h0001);
      wr(virq_pkg::OFS_PINFLG, 8'h00);
      pins(10'h3FF, 8'h00);
      rdchk(virq_pkg::OFS_PINFLG, 8'h00);
      wr(virq_pkg::OFS_IEN1, 8'h00);
      $display("test pins two to nine done");
      wr(virq_pkg::OFS_P1WK, 8'h02);
      pins(10'h3FF, 8'h01);
      wcyc(6);
      chk({15'h0000, halt_wake}, 16'h0000);
      pins(10'h3FF, 8'h03);
      wcyc(6);
      chk({15'h0000, halt_wake}, 16'h0001);
      wr(virq_pkg::OFS_IEN, 8'h80);
      wr(virq_pkg::OFS_IEN1, 8'h02);
      wcyc(2);
      chk({15'h0000, idle_wake}, 16'h0001);
      chk(irq_out.vector, 16'h0043);
      $display("test port1 done");
      end_of_test();
   end
endmodule // tb_vectored_irq_priority_wake
